// File: adcpm_ctrl.sv
// Overview of operation
// - power bits 11 normal, 10 full shutdown, 01 auto shutdown
// - chip select fall starts a conversion and puts track-and-hold into hold, except when it wakes auto shutdown
// - with write bit set, first 12 bits load the control register
// - after a write with sequencer 0 and shadow 1, next 16 bits load shadow
// - normal power kept until a write sets power bits 10 or 01
// - a conversion and its readout take sixteen serial clocks
// - track-and-hold returns to track on the 14th falling edge, except in a shadow frame or full shutdown without a waking write
// - full shutdown powers down, keeps control bits, until power bits change
// - wake from full shutdown needs a full transfer; output stays undriven
// - auto shutdown powers down after each conversion that writes control, holding the sample
// - auto shutdown wakes on chip select fall, track-and-hold goes to track
// - auto wake takes at most 1 us; one dummy transfer at 20 MHz
// - mode undefined at power-on; control valid from third chip select rise
// - output word: leading zero, three channel bits, twelve result bits
// - chip select rising early aborts, tri-states output, keeps control
// - write flag is the first bit; control taken on first 12 edges
// - leading zero at chip select fall, then bits on falling edges, then release
`include "adcpm_params.svh"

module adcpm_ctrl (
  // host clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  // serial link
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        din_in,
  output logic             dout_out,
  output logic             dout_oe_out,
  // converter core
  input  wire logic [11:0] result_in,
  output logic             hold_out,
  output logic             power_on_out,
  output logic             conv_start_out,
  // status
  output logic             full_shdn_out,
  output logic             auto_shdn_out,
  output logic             result_valid_out,
  output logic             timing_err_out,
  output logic             cfg_valid_out,
  output logic [2:0]       channel_out,
  output logic             sequencer_select_out,
  output logic [15:0]      shadow_out
);

  localparam logic [`ADCPM_TMR_W-1:0] QUIET_CYC    = `ADCPM_TMR_W'(`ADCPM_QUIET_CYC);
  localparam logic [`ADCPM_TMR_W-1:0] PWRUP_CYC    = `ADCPM_TMR_W'(`ADCPM_PWRUP_CYC);
  localparam logic [`ADCPM_TMR_W-1:0] AUTOWAKE_CYC = `ADCPM_TMR_W'(`ADCPM_AUTOWAKE_CYC);
  localparam logic [`ADCPM_TMR_W-1:0] CYCLE_CYC    = `ADCPM_TMR_W'(`ADCPM_CYCLE_CYC);

  logic [15:0] rx_word;
  logic        rx_tgl;
  logic        t14_tgl;
  logic [2:0]  sync_q;
  logic [2:0]  sync_d;
  logic        drive_ok;
  logic [15:0] tx_word;

  // ****************************************
  // link domain and crossings
  // ****************************************
  adcpm_link u_link (
    .sclk_in     (sclk_in),
    .cs_n_in     (cs_n_in),
    .din_in      (din_in),
    .dout_out    (dout_out),
    .dout_oe_out (dout_oe_out),
    .nrst_in     (nrst_in),
    .drive_ok_in (drive_ok),
    .tx_word_in  (tx_word),
    .rx_word_out (rx_word),
    .rx_tgl_out  (rx_tgl),
    .t14_tgl_out (t14_tgl)
  );

  adcpm_sync #(.W(3), .RST_VAL(3'h1)) u_sync (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .async_in   ({t14_tgl, rx_tgl, cs_n_in}),
    .sync_out   (sync_q)
  );

  logic cs_fall;
  logic cs_rise;
  logic rx_ev;
  logic t14_ev;
  logic [11:0] rx_ctrl;

  always_comb begin
    cs_fall = sync_d[0] & ~sync_q[0];
    cs_rise = ~sync_d[0] & sync_q[0];
    rx_ev   = sync_d[1] ^ sync_q[1];
    t14_ev  = sync_d[2] ^ sync_q[2];
    rx_ctrl = rx_word[15:4];
  end

  // ****************************************
  // control state
  // ****************************************
  logic [11:0]                ctrl;
  logic [15:0]                shadow;
  adcpm_pkg::adcpm_mode_t     mode;
  adcpm_pkg::adcpm_pwr_t      pwr;
  logic                       shadow_pend;
  logic                       shadow_frame;
  logic                       frame_done;
  logic                       in_frame;
  logic                       hold;
  logic [1:0]                 cfg_cnt;
  logic [`ADCPM_TMR_W-1:0]    pwr_tmr;
  logic [`ADCPM_TMR_W-1:0]    quiet_cnt;
  logic [`ADCPM_TMR_W-1:0]    cyc_cnt;
  logic                       res_valid;
  logic                       tim_err;
  logic                       start;

  logic [11:0]                next_ctrl;
  logic [15:0]                next_shadow;
  adcpm_pkg::adcpm_mode_t     next_mode;
  adcpm_pkg::adcpm_pwr_t      next_pwr;
  logic                       next_shadow_pend;
  logic                       next_shadow_frame;
  logic                       next_frame_done;
  logic                       next_in_frame;
  logic                       next_hold;
  logic [1:0]                 next_cfg_cnt;
  logic [`ADCPM_TMR_W-1:0]    next_pwr_tmr;
  logic [`ADCPM_TMR_W-1:0]    next_quiet_cnt;
  logic [`ADCPM_TMR_W-1:0]    next_cyc_cnt;
  logic                       next_res_valid;
  logic                       next_tim_err;
  logic                       next_start;
  logic                       next_drive_ok;
  logic [15:0]                next_tx_word;
  logic                       wake_write;
  adcpm_pkg::adcpm_mode_t     rx_mode;

  // power bits to mode; 00 names no mode and leaves the mode as it was
  always_comb begin
    rx_mode = mode;
    case ({rx_ctrl[`ADCPM_F_PM_HI], rx_ctrl[`ADCPM_F_PM_LO]})
      2'h3: rx_mode = adcpm_pkg::ADCPM_NORMAL;
      2'h2: rx_mode = adcpm_pkg::ADCPM_FULL_SHDN;
      2'h1: rx_mode = adcpm_pkg::ADCPM_AUTO_SHDN;
      default: rx_mode = mode;
    endcase
    wake_write = rx_ctrl[`ADCPM_F_WRITE] && !shadow_frame
                 && (rx_mode != adcpm_pkg::ADCPM_FULL_SHDN);
  end

  always_comb begin
    next_ctrl         = ctrl;
    next_shadow       = shadow;
    next_mode         = mode;
    next_pwr          = pwr;
    next_shadow_pend  = shadow_pend;
    next_shadow_frame = shadow_frame;
    next_frame_done   = frame_done;
    next_in_frame     = in_frame;
    next_hold         = hold;
    next_cfg_cnt      = cfg_cnt;
    next_pwr_tmr      = pwr_tmr;
    next_quiet_cnt    = (quiet_cnt == '1) ? quiet_cnt : quiet_cnt + 1'b1;
    next_cyc_cnt      = (cyc_cnt == '1) ? cyc_cnt : cyc_cnt + 1'b1;
    next_res_valid    = res_valid;
    next_tim_err      = tim_err;
    next_start        = 1'b0;
    // wake timer runs down to full power
    if (pwr == adcpm_pkg::ADCPM_PWR_WAKE) begin
      if (pwr_tmr == '0) begin
        next_pwr = adcpm_pkg::ADCPM_PWR_ON;
      end else begin
        next_pwr_tmr = pwr_tmr - 1'b1;
      end
    end
    if (cs_fall) begin
      next_in_frame     = 1'b1;
      next_start        = 1'b1;
      next_frame_done   = 1'b0;
      next_shadow_frame = shadow_pend;
      next_cyc_cnt      = '0;
      // a result is trusted only when configured, powered and timed
      next_res_valid    = (cfg_cnt == `ADCPM_CFG_FRAMES) && (pwr == adcpm_pkg::ADCPM_PWR_ON)
                          && (quiet_cnt >= QUIET_CYC) && (cyc_cnt >= CYCLE_CYC);
      next_tim_err      = (quiet_cnt < QUIET_CYC) || (cyc_cnt < CYCLE_CYC)
                          || (pwr == adcpm_pkg::ADCPM_PWR_WAKE);
      if (pwr == adcpm_pkg::ADCPM_PWR_OFF && mode == adcpm_pkg::ADCPM_AUTO_SHDN) begin
        next_pwr     = adcpm_pkg::ADCPM_PWR_WAKE;
        next_pwr_tmr = AUTOWAKE_CYC;
        next_hold    = 1'b0;
      end else begin
        next_hold = 1'b1;
      end
    end
    // 14th edge: back to track, unless this frame feeds the shadow register or full shutdown gets no waking write
    if (t14_ev && !shadow_frame) begin
      if (pwr != adcpm_pkg::ADCPM_PWR_OFF || mode != adcpm_pkg::ADCPM_FULL_SHDN
          || wake_write) begin
        next_hold = 1'b0;
      end
    end
    // 16th edge: the transfer is complete, commit what it carried
    if (rx_ev) begin
      next_frame_done = 1'b1;
      if (shadow_frame) begin
        next_shadow      = rx_word;
        next_shadow_pend = 1'b0;
      end else if (rx_ctrl[`ADCPM_F_WRITE]) begin
        next_ctrl        = rx_ctrl;
        next_mode        = rx_mode;
        next_shadow_pend = !rx_ctrl[`ADCPM_F_SEQ] && rx_ctrl[`ADCPM_F_SHADOW];
        if (pwr == adcpm_pkg::ADCPM_PWR_OFF && wake_write) begin
          next_pwr     = adcpm_pkg::ADCPM_PWR_WAKE;
          next_pwr_tmr = PWRUP_CYC;
        end
      end
    end
    if (cs_rise) begin
      next_in_frame     = 1'b0;
      next_quiet_cnt    = '0;
      next_shadow_frame = 1'b0;
      next_cfg_cnt      = (cfg_cnt == `ADCPM_CFG_FRAMES) ? cfg_cnt : cfg_cnt + 2'h1;
      if (shadow_frame) begin
        next_hold = 1'b0;
      end
      // an aborted frame changes nothing here; a dummy with write clear keeps auto awake
      if (frame_done) begin
        if ((mode == adcpm_pkg::ADCPM_AUTO_SHDN && rx_ctrl[`ADCPM_F_WRITE] && !shadow_frame)
            || (mode == adcpm_pkg::ADCPM_FULL_SHDN && pwr != adcpm_pkg::ADCPM_PWR_WAKE)) begin
          next_pwr  = adcpm_pkg::ADCPM_PWR_OFF;
          next_hold = 1'b1;
        end
      end
    end
  end

  // output word and drive permission, frozen while a frame runs
  always_comb begin
    next_tx_word  = tx_word;
    next_drive_ok = drive_ok;
    if (!in_frame && !cs_fall) begin
      next_tx_word  = {1'b0, ctrl[`ADCPM_F_ADDR_HI:`ADCPM_F_ADDR_LO], result_in};
      next_drive_ok = !(pwr == adcpm_pkg::ADCPM_PWR_OFF
                        && mode == adcpm_pkg::ADCPM_FULL_SHDN);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_d       <= 3'h1;
      ctrl         <= `ADCPM_CTRL_RST;
      shadow       <= `ADCPM_SHADOW_RST;
      mode         <= adcpm_pkg::ADCPM_NORMAL;
      pwr          <= adcpm_pkg::ADCPM_PWR_ON;
      shadow_pend  <= 1'b0;
      shadow_frame <= 1'b0;
      frame_done   <= 1'b0;
      in_frame     <= 1'b0;
      hold         <= 1'b0;
      cfg_cnt      <= 2'h0;
      pwr_tmr      <= '0;
      quiet_cnt    <= '1;
      cyc_cnt      <= '1;
      res_valid    <= 1'b0;
      tim_err      <= 1'b0;
      start        <= 1'b0;
      tx_word      <= 16'h0000;
      drive_ok     <= 1'b1;
    end else begin
      sync_d       <= sync_q;
      ctrl         <= next_ctrl;
      shadow       <= next_shadow;
      mode         <= next_mode;
      pwr          <= next_pwr;
      shadow_pend  <= next_shadow_pend;
      shadow_frame <= next_shadow_frame;
      frame_done   <= next_frame_done;
      in_frame     <= next_in_frame;
      hold         <= next_hold;
      cfg_cnt      <= next_cfg_cnt;
      pwr_tmr      <= next_pwr_tmr;
      quiet_cnt    <= next_quiet_cnt;
      cyc_cnt      <= next_cyc_cnt;
      res_valid    <= next_res_valid;
      tim_err      <= next_tim_err;
      start        <= next_start;
      tx_word      <= next_tx_word;
      drive_ok     <= next_drive_ok;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hold_out             = hold;
  assign power_on_out         = (pwr == adcpm_pkg::ADCPM_PWR_ON);
  assign conv_start_out       = start;
  assign full_shdn_out        = (mode == adcpm_pkg::ADCPM_FULL_SHDN);
  assign auto_shdn_out        = (mode == adcpm_pkg::ADCPM_AUTO_SHDN);
  assign result_valid_out     = res_valid;
  assign timing_err_out       = tim_err;
  assign cfg_valid_out        = (cfg_cnt == `ADCPM_CFG_FRAMES);
  assign channel_out          = ctrl[`ADCPM_F_ADDR_HI:`ADCPM_F_ADDR_LO];
  assign sequencer_select_out = ctrl[`ADCPM_F_SEQ];
  assign shadow_out           = shadow;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  a_hold_on_fall: assert property (cs_fall && !(pwr == adcpm_pkg::ADCPM_PWR_OFF
      && mode == adcpm_pkg::ADCPM_AUTO_SHDN) |=> hold && start)
    else $error("hold not entered at chip select fall");
  a_auto_wake: assert property (cs_fall && pwr == adcpm_pkg::ADCPM_PWR_OFF
      && mode == adcpm_pkg::ADCPM_AUTO_SHDN |=> !hold && pwr == adcpm_pkg::ADCPM_PWR_WAKE)
    else $error("auto shutdown did not wake to track");
  a_ctrl_load: assert property (rx_ev && !shadow_frame && rx_word[15]
      |=> ctrl == $past(rx_word[15:4]))
    else $error("control register not loaded");
  a_shadow_load: assert property (rx_ev && shadow_frame
      |=> shadow == $past(rx_word) && !shadow_pend)
    else $error("shadow register not loaded");
  a_track_edge: assert property (t14_ev && !shadow_frame && !cs_fall
      && pwr == adcpm_pkg::ADCPM_PWR_ON |=> !hold)
    else $error("no track after 14th edge");
  a_auto_down: assert property (cs_rise && frame_done && !cs_fall && rx_word[15]
      && !shadow_frame && mode == adcpm_pkg::ADCPM_AUTO_SHDN
      |=> pwr == adcpm_pkg::ADCPM_PWR_OFF && hold)
    else $error("auto shutdown did not power down");
  a_auto_dummy: assert property (cs_rise && frame_done && !cs_fall && !shadow_frame
      && !rx_word[15] && mode == adcpm_pkg::ADCPM_AUTO_SHDN |=> pwr != adcpm_pkg::ADCPM_PWR_OFF)
    else $error("dummy transfer powered the converter down");
  a_abort_keep: assert property (cs_rise && !frame_done && !rx_ev |=> $stable(ctrl))
    else $error("aborted frame changed control");
  a_wake_bound: assert property (pwr == adcpm_pkg::ADCPM_PWR_WAKE
      |-> ##[0:250] pwr != adcpm_pkg::ADCPM_PWR_WAKE)
    else $error("wake-up took too long");
  a_full_quiet: assert property (pwr == adcpm_pkg::ADCPM_PWR_OFF && !in_frame && !cs_fall
      && mode == adcpm_pkg::ADCPM_FULL_SHDN |=> !drive_ok)
    else $error("output allowed in full shutdown");
  a_mode_full: assert property (rx_ev && !shadow_frame && rx_word[15]
      && rx_word[9:8] == 2'h2 |=> full_shdn_out)
    else $error("full shutdown not selected");

  c_auto_wake: cover property (cs_fall && pwr == adcpm_pkg::ADCPM_PWR_OFF
      && mode == adcpm_pkg::ADCPM_AUTO_SHDN);
  c_shadow: cover property (rx_ev && shadow_frame);
  c_abort: cover property (cs_rise && in_frame && !frame_done);
  c_full_wake: cover property (rx_ev && pwr == adcpm_pkg::ADCPM_PWR_OFF && wake_write);

endmodule

// File: adcpm_host.sv
module adcpm_host (
  // link pins
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      din_out,
  input  wire logic dout_in,
  input  wire logic dout_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // host side of the link, sclk only runs inside a frame
  // ****************************************
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    din_out  = 1'b1;
  end
  // n below 16 rises cs early and aborts the frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r,
                      output logic oe);
    r  = '0;
    #11;
    din_out  = w[15];
    cs_n_out = 1'b0;
    #32;
    // a released line reads as the inverse, so an early release shows up
    r[15] = dout_oe_in ? dout_in : ~dout_in;
    oe    = dout_oe_in;
    for (int k = 1; k <= n; k++) begin
      sclk_out = 1'b0;
      #32;
      sclk_out = 1'b1;
      if (k < 16) din_out = w[15-k];
      #32;
      if (k < 16) r[15-k] = dout_oe_in ? dout_in : ~dout_in;
      oe |= dout_oe_in;
    end
    cs_n_out = 1'b1;
    din_out  = ~din_out; // parked line must not look like stale data
  endtask
endmodule

// File: adcpm_link.sv
`include "adcpm_params.svh"

module adcpm_link (
  // link pins
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        din_in,
  output logic             dout_out,
  output logic             dout_oe_out,
  // from host-clock side, quasi-static during a frame
  input  wire logic        nrst_in,
  input  wire logic        drive_ok_in,
  input  wire logic [15:0] tx_word_in,
  // to host-clock side
  output logic      [15:0] rx_word_out,
  output logic             rx_tgl_out,
  output logic             t14_tgl_out
);

  logic [4:0]  cnt;
  logic [14:0] rx_shift;
  logic        done;
  logic        drv;
  logic [4:0]  next_cnt;
  logic [14:0] next_rx_shift;
  logic        next_done;
  logic        next_dout;
  logic [15:0] tx_shifted;
  logic [15:0] next_rx_word;
  logic        next_rx_tgl;
  logic        next_t14_tgl;

  // ****************************************
  // frame logic, cleared by chip select high
  // ****************************************
  always_comb begin
    next_cnt      = (cnt == 5'h10) ? cnt : cnt + 5'h01;
    next_rx_shift = (cnt < `ADCPM_EDGE_LAST) ? {rx_shift[13:0], din_in} : rx_shift;
    tx_shifted    = tx_word_in << next_cnt;
    next_dout     = (cnt < `ADCPM_EDGE_LAST) ? tx_shifted[15] : 1'b0;
    next_done     = done | (cnt == `ADCPM_EDGE_LAST);
  end

  // clear by the frame's own signal: sclk may stop right after the last bit
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt      <= 5'h00;
      rx_shift <= 15'h0000;
      done     <= 1'b0;
      dout_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      rx_shift <= next_rx_shift;
      done     <= next_done;
      dout_out <= next_dout;
    end
  end

  // drive decision taken at chip select fall; drive_ok_in is frozen while a frame runs
  always_ff @(negedge cs_n_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      drv <= 1'b0;
    end else begin
      drv <= drive_ok_in;
    end
  end

  assign dout_oe_out = drv & ~done;

  // ****************************************
  // captured word and event toggles, survive the frame
  // ****************************************
  always_comb begin
    next_rx_word = rx_word_out;
    next_rx_tgl  = rx_tgl_out;
    next_t14_tgl = t14_tgl_out;
    if (cnt == `ADCPM_EDGE_CTRL) begin
      next_rx_word[15:4] = {rx_shift[10:0], din_in};
    end
    if (cnt == `ADCPM_EDGE_TRACK) begin
      next_t14_tgl = ~t14_tgl_out;
    end
    if (cnt == `ADCPM_EDGE_LAST) begin
      next_rx_word[3:0] = {rx_shift[2:0], din_in};
      next_rx_tgl       = ~rx_tgl_out;
    end
  end

  always_ff @(negedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_word_out <= 16'h0000;
      rx_tgl_out  <= 1'b0;
      t14_tgl_out <= 1'b0;
    end else begin
      rx_word_out <= next_rx_word;
      rx_tgl_out  <= next_rx_tgl;
      t14_tgl_out <= next_t14_tgl;
    end
  end

endmodule

// File: adcpm_params.svh
`ifndef ADCPM_PARAMS_SVH
`define ADCPM_PARAMS_SVH

// ****************************************
// control word layout (bits of the 12-bit control register)
// ****************************************
`define ADCPM_CTRL_W        12
`define ADCPM_WORD_W        16
`define ADCPM_F_WRITE       11
`define ADCPM_F_SEQ         10
`define ADCPM_F_ADDR_HI     8
`define ADCPM_F_ADDR_LO     6
`define ADCPM_F_PM_HI       5
`define ADCPM_F_PM_LO       4
`define ADCPM_F_SHADOW      3
`define ADCPM_CTRL_RST      12'hFFF
`define ADCPM_SHADOW_RST    16'h0000

// ****************************************
// link bit positions (falling sclk edges, counted from zero)
// ****************************************
`define ADCPM_EDGE_CTRL     5'h0B
`define ADCPM_EDGE_TRACK    5'h0D
`define ADCPM_EDGE_LAST     5'h0F
`define ADCPM_CFG_FRAMES    2'h3

// ****************************************
// timing, host clock 200 MHz
// ****************************************
`define ADCPM_REF_PERIOD_NS 5
`define ADCPM_T_QUIET_NS    50
`define ADCPM_T_PWRUP_NS    1000
`define ADCPM_T_AUTOWAKE_NS 1000
`define ADCPM_T_CYCLE_NS    5000
`define ADCPM_QUIET_CYC     ((`ADCPM_T_QUIET_NS + `ADCPM_REF_PERIOD_NS - 1) / `ADCPM_REF_PERIOD_NS)
`define ADCPM_PWRUP_CYC     ((`ADCPM_T_PWRUP_NS + `ADCPM_REF_PERIOD_NS - 1) / `ADCPM_REF_PERIOD_NS)
`define ADCPM_AUTOWAKE_CYC  (`ADCPM_T_AUTOWAKE_NS / `ADCPM_REF_PERIOD_NS)
`define ADCPM_CYCLE_CYC     ((`ADCPM_T_CYCLE_NS + `ADCPM_REF_PERIOD_NS - 1) / `ADCPM_REF_PERIOD_NS)
`define ADCPM_TMR_W         11

`endif

// File: adcpm_pkg.sv
package adcpm_pkg;

  typedef enum logic [1:0] {
    ADCPM_NORMAL,
    ADCPM_FULL_SHDN,
    ADCPM_AUTO_SHDN
  } adcpm_mode_t;

  typedef enum logic [1:0] {
    ADCPM_PWR_ON,
    ADCPM_PWR_WAKE,
    ADCPM_PWR_OFF
  } adcpm_pwr_t;

endpackage

// File: adcpm_sync.sv
module adcpm_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         nrst_in,
  // async levels in, synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // ****************************************
  // two flops per bit
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        next_meta[i] = async_in[i];
        next_sync[i] = meta[i];
      end
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          meta[i]     <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta[i]     <= next_meta[i];
          sync_out[i] <= next_sync[i];
        end
      end
    end
  endgenerate

endmodule

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in;
  logic        nrst_in;
  logic [11:0] result_in;
  logic [11:0] res;
  logic [15:0] seed;
  logic [15:0] rx;
  logic        oe;
  logic [2:0]  prev;
  logic [2:0]  a;
  logic [15:0] s;
  int          failures;
  int          compares;
  wire logic   sclk, cs_n, din, dout, dout_oe, hold, pwr, fsd, asd, rv, cfgv;
  wire logic   sel, terr, cst;
  int          starts = 0;
  int          falls = 0;
  wire logic   [2:0]  chan;
  wire logic   [15:0] shad;
  adcpm_ctrl dut_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
    .result_in(result_in), .hold_out(hold), .power_on_out(pwr), .conv_start_out(cst),
    .full_shdn_out(fsd), .auto_shdn_out(asd), .result_valid_out(rv),
    .timing_err_out(terr), .cfg_valid_out(cfgv), .channel_out(chan),
    .sequencer_select_out(sel), .shadow_out(shad));
  adcpm_host host_u (.cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
    .dout_in(dout), .dout_oe_in(dout_oe));
  // ****************************************
  // helpers
  // ****************************************
  always #2.5 ref_clk_in = ~ref_clk_in;
  // every chip select fall must give exactly one start pulse
  always @(posedge ref_clk_in) begin
    if (cst) starts++;
  end
  always @(negedge cs_n) begin
    falls++;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [15:0] cw(input logic w, input logic [2:0] ad,
                                     input logic [1:0] pm, input logic sh);
    return {w, 1'b0, 1'b0, ad, pm, sh, 7'h00};
  endfunction
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // gap keeps cycle, quiet and power-up spacing, so status must come out clean
  task automatic frame(input logic [15:0] w, input int n);
    @(posedge ref_clk_in);
    result_in <= seed[11:0];
    res = seed[11:0];
    seed = lfsr(seed);
    repeat (4) @(posedge ref_clk_in);
    host_u.xfer(w, n, rx, oe);
    repeat (1100) @(posedge ref_clk_in);
  endtask
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    failures++;
    print_verdict();
  end
  initial begin
    ref_clk_in = 1'b0;
    nrst_in = 1'b0;
    result_in = 12'h000;
    seed = 16'hB19A;
    failures = 0;
    compares = 0;
    repeat (5) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    frame(16'hFFFF, 16);
    frame(16'hFFFF, 16);
    chk_bit("cfg_valid", 1'b0, cfgv);
    chk_bit("sequencer select", 1'b1, sel);
    frame(cw(1'b1, 3'h5, 2'h3, 1'b0), 16);
    chk_bit("cfg_valid", 1'b1, cfgv);
    chk_bit("sequencer select", 1'b0, sel);
    chk_word("channel", 16'h0005, {13'h0000, chan});
    prev = 3'h5;
    for (int i = 0; i < 5; i++) begin
      a = seed[15:13];
      frame(cw(1'b1, a, 2'h3, 1'b0), 16);
      chk_word("read word", {1'b0, prev, res}, rx);
      chk_bit("hold", 1'b0, hold);
      chk_bit("power on", 1'b1, pwr);
      chk_bit("result valid", 1'b1, rv);
      chk_bit("timing error", 1'b0, terr);
      prev = a;
    end
    // back-to-back frames break both the quiet gap and the cycle time
    host_u.xfer(cw(1'b1, prev, 2'h3, 1'b0), 16, rx, oe);
    repeat (6) @(posedge ref_clk_in);
    host_u.xfer(cw(1'b1, prev, 2'h3, 1'b0), 16, rx, oe);
    repeat (1100) @(posedge ref_clk_in);
    chk_bit("timing error", 1'b1, terr);
    chk_bit("result valid", 1'b0, rv);
    frame(cw(1'b1, ~prev, 2'h3, 1'b0), 10);
    chk_word("channel after abort", {13'h0000, prev}, {13'h0000, chan});
    chk_bit("dout_oe after abort", 1'b0, dout_oe);
    frame(cw(1'b1, prev, 2'h2, 1'b0), 16);
    chk_bit("full shutdown", 1'b1, fsd);
    chk_bit("power on", 1'b0, pwr);
    frame(cw(1'b1, prev, 2'h3, 1'b0), 16);
    chk_bit("dout_oe in wake", 1'b0, oe);
    chk_bit("full shutdown", 1'b0, fsd);
    chk_bit("power on after wake", 1'b1, pwr);
    frame(cw(1'b1, prev, 2'h1, 1'b0), 16);
    chk_bit("auto shutdown", 1'b1, asd);
    chk_bit("power on", 1'b0, pwr);
    chk_bit("hold", 1'b1, hold);
    frame(cw(1'b0, ~prev, 2'h3, 1'b0), 16);
    chk_bit("auto kept", 1'b1, asd);
    chk_word("channel kept", {13'h0000, prev}, {13'h0000, chan});
    chk_bit("power on after dummy", 1'b1, pwr);
    frame(cw(1'b1, prev, 2'h3, 1'b1), 16);
    chk_bit("result valid after dummy", 1'b1, rv);
    s = seed;
    frame(s, 16);
    chk_word("shadow", s, shad);
    chk_word("conv starts", falls[15:0], starts[15:0]);
    print_verdict();
  end
endmodule
